/* rtl/eeprom_autoload.sv */
`timescale 1ns/1ns
// Contract
// - Five pins: serial in, serial out, select, own clock, org strap.
// - Store is a 2K-bit serial memory holding configuration.
// - Word format: 16-bit words, 7-bit word address; byte format: bytes, 8-bit byte address.
// - Strap caught at start-up: asserted means word format, else byte.
// - Copy into configuration only when RTS[0] is inactive at start.
// - Check code A868h at word 0; load starts only if it matches.
// - Words 02h..08h give vendor, device and subsystem identifiers.
// - Word 0Ah spreads over 80h[31:21], 84h[3] and A8h[14:13].
// - No-soft-reset set suppresses internal reset on D3hot to D0.
// - Words 0Ch and 0Eh form replay and acknowledge timers at B0h.
// - Word 10h bits 7:0 land in ECh bits 17:10.
// - Words 12h and 14h give transceiver modes at B4h.
// - Word 16h bits 5:0 land in B8h bits 21:16.
// - Word 18h bits 13:0 give the phy parameter at C8h.
// - Word 1Ah bit 0 to C4h bit 15, bits 15:8 to 34h.
// - Word 1Ch low byte gives the revision at 08h.
module eeprom_autoload (
	input wire logic clk,
	input wire logic rst,
	input wire logic [7:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [31:0] rdata,
	input wire logic eeprom_serial_in,
	output logic eeprom_serial_out,
	output logic eeprom_select,
	output logic eeprom_clock_out,
	input wire logic eeprom_org_strap_n,
	input wire logic rts0_n,
	input wire logic d3hot_to_d0,
	output logic soft_reset_cmd,
	output logic [31:0] cfg_ids,
	output logic [31:0] cfg_subsys,
	output logic [7:0] cfg_rev,
	output logic [7:0] cfg_cap_ptr,
	output logic [10:0] cfg_pm_cap,
	output logic cfg_no_soft_reset,
	output logic [1:0] phy_control_bits,
	output logic [31:0] cfg_link_timers,
	output logic [31:0] cfg_xcvr_mode,
	output logic [5:0] cfg_pm_ctrl,
	output logic cfg_rber_en,
	output logic [13:0] cfg_phy_param,
	output logic [7:0] cfg_link_cap,
	output eeprom_loader_pkg::load_state_t state
);
	import eeprom_loader_pkg::*;

	// ****************************************
	// Pins and serial engine
	// ****************************************
	eeprom_rd_if rdi();

	logic [SYNC_W-1:0] pins_q;
	logic settle_end;
	logic [1:0] settle;
	logic word_mode;
	logic loaded;
	logic skipped;
	logic sig_bad;
	logic half;
	logic req;
	logic [6:0] widx; // 128 words fill the 2K-bit store
	logic [7:0] lo_byte;

	pin_sync u_sync (
		.clk(clk),
		.rst(rst),
		.d({rts0_n, eeprom_org_strap_n, eeprom_serial_in}),
		.q(pins_q)
	);

	wire din_s = pins_q[0];
	wire strap_s = ~pins_q[1];
	wire rts_s = ~pins_q[2];

	eeprom_shifter u_shift (
		.clk(clk),
		.rst(rst),
		.rd(rdi),
		.din(din_s),
		.sck(eeprom_clock_out),
		.cs(eeprom_select),
		.dout(eeprom_serial_out)
	);

	assign rdi.req = req;
	assign rdi.word_mode = word_mode;
	assign rdi.waddr = widx;
	assign rdi.hi = half;

	// ****************************************
	// Load sequencing
	// ****************************************
	// Byte format needs two reads per word, low byte first
	wire word_done = state == ST_WAIT && rdi.done && (word_mode || half);
	wire [15:0] ww = word_mode ? rdi.data : {rdi.data[7:0], lo_byte};
	wire sig_ok = ww == SIG_CODE;
	wire ld = word_done && widx != WADDR_SIG;
	assign settle_end = state == ST_SETTLE && settle == SETTLE_CNT;
	wire reload = wr && addr == OFF_CTRL && wdata[CTRL_RELOAD_BIT] &&
		state == ST_DONE;
	wire start_load = settle_end || reload;

	// Strap is only meaningful at start-up
	always_ff @(posedge clk) begin
		if (rst) begin
			word_mode <= 1'b0;
		end else if (settle_end) begin
			word_mode <= strap_s;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state <= ST_SETTLE;
			settle <= 2'h0;
			loaded <= 1'b0;
			skipped <= 1'b0;
			sig_bad <= 1'b0;
			half <= 1'b0;
			req <= 1'b0;
			widx <= WADDR_SIG;
			lo_byte <= 8'h00;
		end else begin
			req <= 1'b0;
			if (start_load) begin
				loaded <= 1'b0;
				skipped <= rts_s;
				sig_bad <= 1'b0;
				widx <= WADDR_SIG;
				half <= 1'b0;
				state <= rts_s ? ST_DONE : ST_REQ;
			end else begin
				case (state)
				ST_SETTLE: begin
					settle <= 2'(settle + 2'h1);
				end
				ST_REQ: begin
					req <= 1'b1;
					state <= ST_WAIT;
				end
				ST_WAIT: begin
					if (rdi.done && !word_mode && !half) begin
						lo_byte <= rdi.data[7:0];
						half <= 1'b1;
						state <= ST_REQ;
					end else if (rdi.done) begin
						half <= 1'b0;
						if (widx == WADDR_SIG && !sig_ok) begin
							skipped <= 1'b1;
							sig_bad <= 1'b1;
							state <= ST_DONE;
						end else if (widx == WADDR_LAST) begin
							loaded <= 1'b1;
							state <= ST_DONE;
						end else begin
							widx <= 7'(widx + 7'h01);
							state <= ST_REQ;
						end
					end
				end
				ST_DONE: begin
					req <= 1'b0;
				end
				default: begin
					state <= ST_DONE;
				end
				endcase
			end
		end
	end

	// ****************************************
	// Configuration targets
	// ****************************************
	// A new load first returns every target to its default
	always_ff @(posedge clk) begin
		if (rst || start_load) begin
			cfg_ids <= {DEF_DID, DEF_VID};
			cfg_subsys <= DEF_SUBSYS;
			cfg_pm_cap <= DEF_PMC;
			cfg_no_soft_reset <= DEF_NSR;
			phy_control_bits <= DEF_XPIP;
			cfg_link_timers <= DEF_TMR;
			cfg_link_cap <= DEF_LINK;
			cfg_xcvr_mode <= DEF_XCVR;
			cfg_pm_ctrl <= DEF_PMCTL;
			cfg_phy_param <= DEF_PHY;
			cfg_rber_en <= DEF_RBER;
			cfg_cap_ptr <= DEF_CAPP;
			cfg_rev <= DEF_REV;
		end else if (ld) begin
			case (widx)
			W_VID: cfg_ids[15:0] <= ww;
			W_DID: cfg_ids[31:16] <= ww;
			W_SVID: cfg_subsys[15:0] <= ww;
			W_SID: cfg_subsys[31:16] <= ww;
			W_PM: begin
				cfg_pm_cap <= ww[10:0];
				cfg_no_soft_reset <= ww[11];
				phy_control_bits <= ww[13:12];
			end
			W_REPLAY: cfg_link_timers[15:0] <= ww;
			W_ACKLAT: cfg_link_timers[31:16] <= ww;
			W_LINK: cfg_link_cap <= ww[7:0];
			W_XCV_LO: cfg_xcvr_mode[15:0] <= ww;
			W_XCV_HI: cfg_xcvr_mode[31:16] <= ww;
			W_PMCTL: cfg_pm_ctrl <= ww[5:0];
			W_PHY: cfg_phy_param <= ww[13:0];
			W_RBER: begin
				cfg_rber_en <= ww[0];
				cfg_cap_ptr <= ww[15:8];
			end
			WADDR_LAST: cfg_rev <= ww[7:0];
			default: cfg_rev <= cfg_rev;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			soft_reset_cmd <= 1'b0;
		end else begin
			soft_reset_cmd <= d3hot_to_d0 && !cfg_no_soft_reset;
		end
	end

	// ****************************************
	// Register read port
	// ****************************************
	wire busy = state != ST_DONE;
	wire [31:0] stat_word = {27'h0, sig_bad, word_mode, skipped, loaded,
		busy};
	wire [31:0] rd_mux =
		(addr == OFF_ID) ? cfg_ids :
		(addr == OFF_REV) ? {24'h0, cfg_rev} :
		(addr == OFF_SUBSYS) ? cfg_subsys :
		(addr == OFF_CAPP) ? {24'h0, cfg_cap_ptr} :
		(addr == OFF_PMC) ? (32'(cfg_pm_cap) << PMC_LSB) :
		(addr == OFF_PMCSR) ? (32'(cfg_no_soft_reset) << NSR_BIT) :
		(addr == OFF_XPIP) ? (32'(phy_control_bits) << XPIP_LSB) :
		(addr == OFF_TMR) ? cfg_link_timers :
		(addr == OFF_XCVR) ? cfg_xcvr_mode :
		(addr == OFF_PMCTL) ? (32'(cfg_pm_ctrl) << PMCTL_LSB) :
		(addr == OFF_RBER) ? (32'(cfg_rber_en) << RBER_BIT) :
		(addr == OFF_PHY) ? {18'h0, cfg_phy_param} :
		(addr == OFF_LINK) ? (32'(cfg_link_cap) << LINK_LSB) :
		(addr == OFF_STAT) ? stat_word :
		32'h0000_0000;

	// Unmapped and control addresses read zero
	always_ff @(posedge clk) begin
		if (rst) begin
			rdata <= 32'h0000_0000;
		end else begin
			rdata <= rd ? rd_mux : 32'h0000_0000;
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	property p_sck_cs;
		eeprom_clock_out |-> eeprom_select;
	endproperty
	a_sck_cs: assert property (p_sck_cs)
		else $error("serial clock toggles without select");

	property p_frame_start;
		$rose(eeprom_select) |-> !eeprom_clock_out[*8] ##1 eeprom_clock_out;
	endproperty
	a_frame_start: assert property (p_frame_start)
		else $error("first serial clock edge misplaced");

	property p_waddr;
		rdi.req |-> rdi.waddr <= WADDR_LAST && state == ST_WAIT;
	endproperty
	a_waddr: assert property (p_waddr)
		else $error("read address out of table range");

	property p_strap;
		state != ST_SETTLE && $past(state) != ST_SETTLE |->
			$stable(word_mode);
	endproperty
	a_strap: assert property (p_strap)
		else $error("format changed after start-up");

	property p_rts_skip;
		start_load && rts_s |=> state == ST_DONE && skipped ##1 !rdi.req;
	endproperty
	a_rts_skip: assert property (p_rts_skip)
		else $error("load ran with RTS asserted");

	property p_sig_fail;
		word_done && widx == WADDR_SIG && !sig_ok |=>
			skipped && sig_bad && !loaded && state == ST_DONE;
	endproperty
	a_sig_fail: assert property (p_sig_fail)
		else $error("bad check code did not stop the load");

	property p_vid;
		ld && widx == W_VID |=> cfg_ids[15:0] == $past(ww);
	endproperty
	a_vid: assert property (p_vid)
		else $error("vendor identifier not loaded");

	property p_pm;
		ld && widx == W_PM |=> cfg_pm_cap == $past(ww[10:0]) &&
			phy_control_bits == $past(ww[13:12]);
	endproperty
	a_pm: assert property (p_pm)
		else $error("power capability word misplaced");

	property p_nsr;
		d3hot_to_d0 |=> soft_reset_cmd == !$past(cfg_no_soft_reset);
	endproperty
	a_nsr: assert property (p_nsr)
		else $error("internal reset command disagrees with setting");

	property p_acklat;
		ld && widx == W_ACKLAT |=> cfg_link_timers[31:16] == $past(ww);
	endproperty
	a_acklat: assert property (p_acklat)
		else $error("acknowledge latency timer not loaded");

	property p_phy;
		ld && widx == W_PHY |=> cfg_phy_param == $past(ww[13:0]);
	endproperty
	a_phy: assert property (p_phy)
		else $error("phy parameter not loaded");

	property p_default;
		state == ST_DONE && skipped |->
			cfg_phy_param == DEF_PHY && cfg_cap_ptr == DEF_CAPP &&
			cfg_ids == {DEF_DID, DEF_VID};
	endproperty
	a_default: assert property (p_default)
		else $error("skipped load changed a default");

	c_loaded: cover property (state == ST_DONE && loaded);
	c_byte_load: cover property (loaded && !word_mode);
	c_sig_bad: cover property (sig_bad);
	c_soft_reset: cover property (soft_reset_cmd);
endmodule

/* rtl/eeprom_loader_pkg.sv */
package eeprom_loader_pkg;

	// ****************************************
	// Timing
	// ****************************************
	localparam int CLK_PERIOD_NS = 10;
	localparam int EE_HALF_NS = 80;
	localparam int EE_HALF_CYC =
		(EE_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [3:0] EE_HALF_CNT = 4'(EE_HALF_CYC - 1);
	localparam logic [1:0] SETTLE_CNT = 2'h3;

	// ****************************************
	// Serial framing
	// ****************************************
	localparam logic [1:0] EE_OP_READ = 2'h2;
	localparam logic [4:0] EE_NOUT_WORD = 5'h0B;
	localparam logic [4:0] EE_NOUT_BYTE = 5'h0C;
	localparam logic [4:0] EE_NIN_WORD = 5'h10;
	localparam logic [4:0] EE_NIN_BYTE = 5'h08;
	localparam logic [15:0] SIG_CODE = 16'hA868;
	localparam int SYNC_W = 3;
	localparam logic [SYNC_W-1:0] SYNC_RST = 3'h6;

	// ****************************************
	// Word indices in the store
	// ****************************************
	localparam logic [6:0] WADDR_SIG = 7'h00;
	localparam logic [6:0] W_VID = 7'h01;
	localparam logic [6:0] W_DID = 7'h02;
	localparam logic [6:0] W_SVID = 7'h03;
	localparam logic [6:0] W_SID = 7'h04;
	localparam logic [6:0] W_PM = 7'h05;
	localparam logic [6:0] W_REPLAY = 7'h06;
	localparam logic [6:0] W_ACKLAT = 7'h07;
	localparam logic [6:0] W_LINK = 7'h08;
	localparam logic [6:0] W_XCV_LO = 7'h09;
	localparam logic [6:0] W_XCV_HI = 7'h0A;
	localparam logic [6:0] W_PMCTL = 7'h0B;
	localparam logic [6:0] W_PHY = 7'h0C;
	localparam logic [6:0] W_RBER = 7'h0D;
	localparam logic [6:0] WADDR_LAST = 7'h0E;

	// ****************************************
	// Register offsets and field positions
	// ****************************************
	localparam logic [7:0] OFF_ID = 8'h00;
	localparam logic [7:0] OFF_REV = 8'h08;
	localparam logic [7:0] OFF_SUBSYS = 8'h2C;
	localparam logic [7:0] OFF_CAPP = 8'h34;
	localparam logic [7:0] OFF_PMC = 8'h80;
	localparam logic [7:0] OFF_PMCSR = 8'h84;
	localparam logic [7:0] OFF_XPIP = 8'hA8;
	localparam logic [7:0] OFF_TMR = 8'hB0;
	localparam logic [7:0] OFF_XCVR = 8'hB4;
	localparam logic [7:0] OFF_PMCTL = 8'hB8;
	localparam logic [7:0] OFF_RBER = 8'hC4;
	localparam logic [7:0] OFF_PHY = 8'hC8;
	localparam logic [7:0] OFF_LINK = 8'hEC;
	localparam logic [7:0] OFF_CTRL = 8'hF0;
	localparam logic [7:0] OFF_STAT = 8'hF4;
	localparam int PMC_LSB = 21;
	localparam int NSR_BIT = 3;
	localparam int XPIP_LSB = 13;
	localparam int PMCTL_LSB = 16;
	localparam int RBER_BIT = 15;
	localparam int LINK_LSB = 10;
	localparam int CTRL_RELOAD_BIT = 0;

	// ****************************************
	// Values after reset
	// ****************************************
	localparam logic [15:0] DEF_VID = 16'h1B2C; // Arbitrary value
	localparam logic [15:0] DEF_DID = 16'h0A01; // Arbitrary value
	localparam logic [31:0] DEF_SUBSYS = 32'h0000_0000;
	localparam logic [10:0] DEF_PMC = 11'h23E;
	localparam logic DEF_NSR = 1'b1;
	localparam logic [1:0] DEF_XPIP = 2'h0;
	localparam logic [31:0] DEF_TMR = 32'h0000_0000;
	localparam logic [31:0] DEF_XCVR = 32'h0000_0000;
	localparam logic [5:0] DEF_PMCTL = 6'h01;
	localparam logic DEF_RBER = 1'b1;
	localparam logic [7:0] DEF_CAPP = 8'h80;
	localparam logic [13:0] DEF_PHY = 14'h0200;
	localparam logic [7:0] DEF_LINK = 8'h0F;
	localparam logic [7:0] DEF_REV = 8'h00;

	typedef enum logic [1:0] {
		ST_SETTLE = 2'b00,
		ST_REQ = 2'b01,
		ST_WAIT = 2'b10,
		ST_DONE = 2'b11
	} load_state_t;

endpackage

/* rtl/eeprom_rd_if.sv */
`timescale 1ns/1ns
interface eeprom_rd_if;
	logic req;
	logic word_mode;
	logic [6:0] waddr;
	logic hi;
	logic done;
	logic [15:0] data;
	modport master(output req, word_mode, waddr, hi, input done, data);
	modport engine(input req, word_mode, waddr, hi, output done, data);
endinterface

/* rtl/pin_sync.sv */
`timescale 1ns/1ns
module pin_sync (
	input wire logic clk,
	input wire logic rst,
	input wire logic [eeprom_loader_pkg::SYNC_W-1:0] d,
	output logic [eeprom_loader_pkg::SYNC_W-1:0] q
);
	import eeprom_loader_pkg::*;

	logic [SYNC_W-1:0] stage1;

	always_ff @(posedge clk) begin
		if (rst) begin
			stage1 <= SYNC_RST;
			q <= SYNC_RST;
		end else begin
			stage1 <= d;
			q <= stage1;
		end
	end
endmodule

/* rtl/eeprom_shifter.sv */
`timescale 1ns/1ns
module eeprom_shifter (
	input wire logic clk,
	input wire logic rst,
	eeprom_rd_if.engine rd,
	input wire logic din,
	output logic sck,
	output logic cs,
	output logic dout
);
	import eeprom_loader_pkg::*;

	logic active;
	logic tail;
	logic [3:0] div;
	logic [4:0] bitn;
	logic [11:0] sh;
	logic [15:0] rx;

	wire tick = div == EE_HALF_CNT;
	wire [4:0] nout = rd.word_mode ? EE_NOUT_WORD : EE_NOUT_BYTE;
	wire [4:0] nin = rd.word_mode ? EE_NIN_WORD : EE_NIN_BYTE;
	wire [4:0] nlast = 5'(nout + nin - 5'h01);
	wire [4:0] olast = 5'(nout - 5'h01);
	// Start bit, opcode, address; both formats pad the unused top address bit
	wire [11:0] frame = rd.word_mode ?
		{1'b1, EE_OP_READ, 1'b0, rd.waddr, 1'b0} :
		{1'b1, EE_OP_READ, 1'b0, rd.waddr, rd.hi};

	always_ff @(posedge clk) begin
		if (rst) begin
			active <= 1'b0;
			tail <= 1'b0;
			div <= 4'h0;
			bitn <= 5'h00;
			sh <= 12'h000;
			rx <= 16'h0000;
			sck <= 1'b0;
			cs <= 1'b0;
			dout <= 1'b0;
			rd.done <= 1'b0;
			rd.data <= 16'h0000;
		end else begin
			rd.done <= 1'b0;
			if (!active && !tail && rd.req) begin
				active <= 1'b1;
				cs <= 1'b1;
				sh <= frame;
				dout <= frame[11];
				div <= 4'h0;
				bitn <= 5'h00;
				sck <= 1'b0;
			end else if (active || tail) begin
				div <= tick ? 4'h0 : 4'(div + 4'h1);
				// Tail keeps select low one half period between reads
				if (tick && tail) begin
					tail <= 1'b0;
					rd.done <= 1'b1;
					rd.data <= rd.word_mode ? rx : {8'h00, rx[7:0]};
				end else if (tick && !sck) begin
					sck <= 1'b1;
				end else if (tick) begin
					sck <= 1'b0;
					bitn <= 5'(bitn + 5'h01);
					sh <= {sh[10:0], 1'b0};
					dout <= (bitn < olast) ? sh[10] : 1'b0;
					// Data is valid after the rising edge
					if (bitn >= nout) begin
						rx <= {rx[14:0], din};
					end
					if (bitn == nlast) begin
						active <= 1'b0;
						cs <= 1'b0;
						tail <= 1'b1;
					end
				end
			end
		end
	end
endmodule

/* sim/eeprom_model.sv */
`timescale 1ns/1ns
module eeprom_model (
	input wire logic clk,
	input wire logic sel,
	input wire logic sck,
	input wire logic si,
	input wire logic word_org,
	output logic so,
	output logic err,
	output int frames
);
	logic [15:0] mem [0:127];
	logic [11:0] sh;
	logic [15:0] dat;
	logic drv;
	int cnt, nout, idx, nxt;
	initial begin
		so = 1'b0;
		err = 1'b0;
		frames = 0;
		cnt = 0;
		drv = 1'b0;
		nxt = 0;
	end
	// Released line keeps moving so a stale bit cannot pass as data
	always @(posedge clk) begin
		if (!drv)
			so <= ~so;
	end
	always @(posedge sck) begin
		if (sel) begin
			nout = word_org ? 11 : 12;
			cnt = cnt + 1;
			if (cnt <= nout)
				sh = {sh[10:0], si};
			if (cnt == nout) begin
				idx = word_org ? sh[7:0] : sh[8:0];
				// Start bit, read opcode, unused top address bit
				if ((word_org ? sh[10:7] : sh[11:8]) !== 4'b1100)
					err = 1'b1;
				if (idx != 0 && idx != nxt)
					err = 1'b1;
				nxt = idx + 1;
				if (word_org)
					dat = mem[idx];
				else
					dat = {idx[0] ? mem[idx/2][15:8] : mem[idx/2][7:0], 8'h00};
				drv = 1'b1;
				so <= 1'b0;
			end else if (cnt > nout) begin
				so <= dat[15];
				dat = dat << 1;
			end
		end
	end
	always @(negedge sel) begin
		if (cnt != 0) begin
			if (cnt != nout + (word_org ? 16 : 8))
				err = 1'b1;
			frames = frames + 1;
		end
		cnt = 0;
		drv = 1'b0;
	end
endmodule

/* sim/eeprom_autoload_tb.sv */
`timescale 1ns/1ns
module eeprom_autoload_tb;
	import eeprom_loader_pkg::*;
	logic clk, rst, wr, rd, d3, sin, sout, sel, sck, srst;
	logic strap_n, rts_n, nsr, rber, merr;
	logic [7:0] addr, rev, cap, lcap;
	logic [31:0] wdata, rdata, ids, sub, tmr, xcv;
	logic [10:0] pmc;
	logic [1:0] pctl;
	logic [5:0] pmct;
	logic [13:0] phy;
	int frames, f0, failures, check_count;
	load_state_t state;
	logic [15:0] img [0:14] = '{16'hA868, 16'hC3A5, 16'h5AE1, 16'h1234,
		16'h8765, 16'h25A5, 16'hF00F, 16'h0FF0, 16'h00B6, 16'hA1B2,
		16'hC3D4, 16'h002A, 16'h2D3C, 16'h40FE, 16'h0077};

	eeprom_autoload DUT (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd), .rdata(rdata), .eeprom_serial_in(sin),
		.eeprom_serial_out(sout), .eeprom_select(sel),
		.eeprom_clock_out(sck), .eeprom_org_strap_n(strap_n),
		.rts0_n(rts_n), .d3hot_to_d0(d3), .soft_reset_cmd(srst),
		.cfg_ids(ids), .cfg_subsys(sub), .cfg_rev(rev), .cfg_cap_ptr(cap),
		.cfg_pm_cap(pmc), .cfg_no_soft_reset(nsr),
		.phy_control_bits(pctl), .cfg_link_timers(tmr),
		.cfg_xcvr_mode(xcv), .cfg_pm_ctrl(pmct), .cfg_rber_en(rber),
		.cfg_phy_param(phy), .cfg_link_cap(lcap), .state(state));
	eeprom_model mem_i (.clk(clk), .sel(sel), .sck(sck), .si(sout),
		.word_org(!strap_n), .so(sin), .err(merr), .frames(frames));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// ********
	// Tasks
	// ********
	task automatic chk(input string n, input logic [31:0] e, g);
		check_count++;
		if (g !== e) begin
			failures++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic end_sim;
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic do_reset(input logic s, input logic r);
		@(posedge clk);
		rst <= 1'b1;
		strap_n <= s;
		rts_n <= r;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
	endtask
	task automatic wait_st(input bit want);
		int i;
		for (i = 0; i < 20000; i++) begin
			@(posedge clk);
			#1;
			if ((state === ST_DONE) == want) break;
		end
		if (i == 20000) begin
			failures++;
			$display("ERROR loader state expected %b seen timeout", want);
			end_sim();
		end
	endtask
	task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		d = rdata;
	endtask
	task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		#1;
	endtask
	task automatic st_chk(input logic [31:0] e);
		logic [31:0] d;
		reg_rd(8'hF4, d);
		chk("status", e, d);
	endtask
	task automatic pulse_d3(input logic e);
		@(posedge clk);
		d3 <= 1'b1;
		@(posedge clk);
		d3 <= 1'b0;
		#1;
		chk("soft_rst", e, srst);
		@(posedge clk);
		#1;
		chk("soft_rst_end", 0, srst);
	endtask
	task automatic check_cfg(input bit ld);
		chk("ids", ld ? {img[2], img[1]} : {DEF_DID, DEF_VID}, ids);
		chk("subsys", ld ? {img[4], img[3]} : DEF_SUBSYS, sub);
		chk("pm_cap", ld ? img[5][10:0] : DEF_PMC, pmc);
		chk("nsr", ld ? img[5][11] : DEF_NSR, nsr);
		chk("phy_ctl", ld ? img[5][13:12] : DEF_XPIP, pctl);
		chk("timers", ld ? {img[7], img[6]} : DEF_TMR, tmr);
		chk("link_cap", ld ? img[8][7:0] : DEF_LINK, lcap);
		chk("xcvr", ld ? {img[10], img[9]} : DEF_XCVR, xcv);
		chk("pm_ctrl", ld ? img[11][5:0] : DEF_PMCTL, pmct);
		chk("phy", ld ? img[12][13:0] : DEF_PHY, phy);
		chk("rber", ld ? img[13][0] : DEF_RBER, rber);
		chk("cap_ptr", ld ? img[13][15:8] : DEF_CAPP, cap);
		chk("rev", ld ? img[14][7:0] : DEF_REV, rev);
	endtask

	// ********
	// Scenarios
	// ********
	task automatic t_word;
		logic [31:0] d;
		f0 = frames;
		do_reset(1'b0, 1'b1);
		wait_st(1'b1);
		chk("frames", 15, frames - f0);
		check_cfg(1'b1);
		st_chk(32'h0A);
		reg_rd(8'h80, d);
		chk("rd80", {img[5][10:0], 21'h0}, d);
		reg_rd(8'h84, d);
		chk("rd84", {28'h0, img[5][11], 3'h0}, d);
		reg_rd(8'hA8, d);
		chk("rdA8", {17'h0, img[5][13:12], 13'h0}, d);
		reg_rd(8'hEC, d);
		chk("rdEC", {14'h0, img[8][7:0], 10'h0}, d);
		reg_rd(8'h08, d);
		chk("rd08", {24'h0, img[14][7:0]}, d);
		reg_rd(8'h2C, d);
		chk("rd2C", {img[4], img[3]}, d);
		reg_rd(8'h34, d);
		chk("rd34", {24'h0, img[13][15:8]}, d);
		reg_rd(8'hB0, d);
		chk("rdB0", {img[7], img[6]}, d);
		reg_rd(8'hB4, d);
		chk("rdB4", {img[10], img[9]}, d);
		reg_rd(8'hB8, d);
		chk("rdB8", {10'h0, img[11][5:0], 16'h0}, d);
		reg_rd(8'hC4, d);
		chk("rdC4", {16'h0, img[13][0], 15'h0}, d);
		reg_rd(8'hC8, d);
		chk("rdC8", {18'h0, img[12][13:0]}, d);
		reg_rd(8'h00, d);
		chk("rd00", {img[2], img[1]}, d);
		@(posedge clk);
		#1;
		chk("rd_idle", 0, rdata);
		reg_rd(8'h10, d);
		chk("unmapped", 0, d);
		reg_wr(8'h00, 32'h0);
		chk("ids_kept", {img[2], img[1]}, ids);
		pulse_d3(1'b1);
	endtask
	task automatic t_badsig;
		f0 = frames;
		mem_i.mem[0] = 16'hA869;
		reg_wr(8'hF0, 32'h1);
		wait_st(1'b0);
		wait_st(1'b1);
		chk("frames", 1, frames - f0);
		check_cfg(1'b0);
		st_chk(32'h1C);
		mem_i.mem[0] = 16'hA868;
	endtask
	task automatic t_rts;
		f0 = frames;
		do_reset(1'b1, 1'b0);
		wait_st(1'b1);
		chk("frames", 0, frames - f0);
		check_cfg(1'b0);
		st_chk(32'h04);
		pulse_d3(1'b0);
	endtask
	task automatic t_byte;
		f0 = frames;
		do_reset(1'b1, 1'b1);
		repeat (200) @(posedge clk);
		// Reload request during a running load must be ignored
		reg_wr(8'hF0, 32'h1);
		wait_st(1'b1);
		chk("frames", 30, frames - f0);
		check_cfg(1'b1);
		st_chk(32'h02);
	endtask

	initial begin
		rst = 1'b1;
		addr = 8'h00;
		wdata = 32'h0;
		wr = 1'b0;
		rd = 1'b0;
		d3 = 1'b0;
		strap_n = 1'b0;
		rts_n = 1'b1;
		for (int i = 0; i < 15; i++)
			mem_i.mem[i] = img[i];
		t_word();
		t_badsig();
		t_rts();
		t_byte();
		chk("link_err", 0, merr);
		end_sim();
	end
endmodule
